// ---- shared/cssc_defs.vh ----
// Constants for the clock source and start-up control block.
`ifndef CSSC_DEFS_VH
`define CSSC_DEFS_VH
// ---------------------------------------------------------------
// Register offsets (byte addresses)
// ---------------------------------------------------------------
`define CSSC_OFF_CTRL 8'h00
`define CSSC_OFF_STATUS 8'h04
`define CSSC_OFF_TRIM 8'h08
`define CSSC_OFF_FUSE 8'h0c
// ---------------------------------------------------------------
// Clock source select codes
// ---------------------------------------------------------------
`define CSSC_SRC_XCVR_MIN 4'h6
`define CSSC_SRC_LP128 4'h3
`define CSSC_SRC_RC 4'h2
`define CSSC_SRC_EXT 4'h0
// ---------------------------------------------------------------
// Shipped fuse values
// ---------------------------------------------------------------
`define CSSC_SHIP_SRC 4'h2
`define CSSC_SHIP_SUT 2'h2
`define CSSC_SHIP_DIV8 1'b0
// ---------------------------------------------------------------
// Timing counts
// ---------------------------------------------------------------
`define CSSC_TOUT_SHORT 14'd512
`define CSSC_TOUT_LONG 14'd8192
`define CSSC_START_WAKE 16'd6
`define CSSC_START_RESET 16'd14
`define CSSC_START_MAX 16'd32768
// ---------------------------------------------------------------
// Control register fields
// ---------------------------------------------------------------
`define CSSC_CTRL_CORE 0
`define CSSC_CTRL_PERIPH 1
`define CSSC_CTRL_CONV 2
`define CSSC_CTRL_ASY 3
`define CSSC_CTRL_WAKE 4
`define CSSC_TRIM_RESET 8'h80
`endif

// ---- logic/cssc_clock_startup.v ----
// Clock source select, start-up reset sequencing and clock gating.
`timescale 1ns/1ps
`include "cssc_defs.vh"

// Overview of operation
// - Source select 1111..0110 transceiver, 0011 low 128k, 0010 RC, 0000 external.
// - A fuse bit read as one is unprogrammed, zero is programmed.
// - Shipped: source 0010, start-up 10, divide-by-eight programmed, 1 MHz.
// - Internal reset stays asserted a time-out after other resets release.
// - Time-out counted in watchdog oscillator cycles, chosen by fuse fields.
// - Time-out lengths are 0, 512 or 8192 watchdog cycles.
// - Ripple counter on selected oscillator holds reset for start-up cycles.
// - Reset applies time-out plus start-up; wake applies start-up only.
// - Factory calibration byte copied into trim register during reset.
// - Software may write trim register to retune the RC oscillator.
// - With RC source, watchdog oscillator still times the reset time-out.
// - RC start-up field 00, 01, 10 give 6 CK/14CK, plus 4 or 64 ms; 11 reserved.
// - Transceiver clock always comes from the 16 MHz crystal.
// - Prescaled clock distributed to domains, gated by sleep mode.
// - Stopping core clock freezes the processor core.
// - Program memory clock is gated together with the core clock.
// - Async interrupt and two-wire detection work with peripheral clock halted.
// - Async timer has own domain and counts during sleep.
// - Converter domain keeps running when core and peripheral halt.
// - Start-up count depends on clock type, 6 up to 16K cycles.
module cssc_clock_startup (
	// Clock and reset
	input wire clk_i,
	input wire rst_i,
	// Fuse storage and factory calibration
	input wire [3:0] clock_source_select_fuses_i,
	input wire [1:0] startup_time_fuses_i,
	input wire divide_by_eight_fuse_i,
	input wire [7:0] factory_cal_i,
	// Oscillator tick pins from outside the clock domain
	input wire wdt_osc_i,
	input wire sel_osc_i,
	input wire xtal16_osc_i,
	input wire async_osc_i,
	// Asynchronous wake events
	input wire async_wake_i,
	// Wishbone slave
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	// Clock enables and internal reset
	output reg internal_reset_o,
	output reg core_clock_en_o,
	output reg program_memory_clock_en_o,
	output reg peripheral_clock_en_o,
	output reg converter_clock_en_o,
	output reg async_timer_clock_en_o,
	output reg xcvr_clock_en_o,
	output reg async_detect_en_o,
	output reg [7:0] oscillator_trim_value_o,
	output reg div8_o
);

	// -----------------------------------------------------------
	// Sequencer states
	// -----------------------------------------------------------
	localparam ST_TOUT = 4'b0001;
	localparam ST_START = 4'b0010;
	localparam ST_RUN = 4'b0100;
	localparam ST_SLEEP = 4'b1000;

	// -----------------------------------------------------------
	// Synchronisers and edge detect
	// -----------------------------------------------------------
	reg [3:0] sync1, sync2, sync3;
	reg wake_s1, wake_s2;
	wire wdt_tick = sync2[0] & ~sync3[0];
	wire osc_tick = sync2[1] & ~sync3[1];
	wire xtal_tick = sync2[2] & ~sync3[2];
	wire asy_tick = sync2[3] & ~sync3[3];

	always @(posedge clk_i) begin
		sync1 <= {async_osc_i, xtal16_osc_i, sel_osc_i, wdt_osc_i};
		sync2 <= sync1;
		sync3 <= sync2;
		wake_s1 <= async_wake_i;
		wake_s2 <= wake_s1;
	end

	// -----------------------------------------------------------
	// Fuse latch
	// -----------------------------------------------------------
	reg [3:0] src;
	reg [1:0] startup_time_fuses;
	reg div8;

	always @(posedge clk_i) begin
		if (rst_i) begin
			src <= clock_source_select_fuses_i;
			startup_time_fuses <= startup_time_fuses_i;
			div8 <= divide_by_eight_fuse_i;
		end
	end

	// -----------------------------------------------------------
	// Decode of time-out and start-up counts
	// -----------------------------------------------------------
	function [13:0] tout_len;
		input [3:0] s;
		input [1:0] t;
		reg [2:0] code;
		begin
			code = 3'd0;
			if (s >= `CSSC_SRC_XCVR_MIN) begin
				code = {s[0], t};
				case (code)
					3'd2, 3'd5: tout_len = 14'd0;
					3'd0, 3'd3, 3'd6: tout_len = `CSSC_TOUT_SHORT;
					default: tout_len = `CSSC_TOUT_LONG;
				endcase
			end else begin
				case (t)
					2'd1: tout_len = `CSSC_TOUT_SHORT;
					2'd2: tout_len = `CSSC_TOUT_LONG;
					default: tout_len = 14'd0;
				endcase
			end
		end
	endfunction

	function [15:0] start_len;
		input [3:0] s;
		input [1:0] t;
		input from_reset;
		reg [2:0] code;
		begin
			code = {s[0], t};
			if (s >= `CSSC_SRC_XCVR_MIN) begin
				if (code < 3'd2)
					start_len = 16'd258;
				else if (code < 3'd5)
					start_len = 16'd1024;
				else
					start_len = 16'd16384;
			end else if (from_reset)
				start_len = `CSSC_START_RESET;
			else
				start_len = `CSSC_START_WAKE;
		end
	endfunction

	// Reserved codes fall back to the shipped source and start-up values.
	wire src_reserved = (src == 4'h1) || (src == 4'h4) || (src == 4'h5);
	wire sut_reserved = (src < `CSSC_SRC_XCVR_MIN) && (startup_time_fuses == 2'h3);
	wire [3:0] eff_src = src_reserved ? `CSSC_SHIP_SRC : src;
	wire [1:0] eff_sut = sut_reserved ? `CSSC_SHIP_SUT : startup_time_fuses;

	// -----------------------------------------------------------
	// Registers
	// -----------------------------------------------------------
	reg [4:0] ctrl;
	reg [3:0] state;
	reg from_reset;
	reg [13:0] tout_cnt;
	reg [15:0] start_cnt;
	reg [31:0] next_rdata;
	wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire wb_wr = wb_req & wb_we_i & wb_sel_i[0];

	always @* begin
		case (wb_adr_i)
			`CSSC_OFF_CTRL: next_rdata = {27'h0, ctrl};
			`CSSC_OFF_STATUS: next_rdata = {27'h0, from_reset, state};
			`CSSC_OFF_TRIM: next_rdata = {24'h0, oscillator_trim_value_o};
			`CSSC_OFF_FUSE: next_rdata = {25'h0, div8, startup_time_fuses, src};
			default: next_rdata = 32'h0;
		endcase
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
			ctrl <= 5'h0f;
		end else begin
			wb_ack_o <= wb_req;
			wb_dat_o <= wb_req ? next_rdata : 32'h0;
			if (wb_wr && wb_adr_i == `CSSC_OFF_CTRL)
				ctrl <= wb_dat_i[4:0];
			else if (state != ST_RUN)
				ctrl[`CSSC_CTRL_WAKE] <= 1'b0;
		end
	end

	// Trim register: factory value during reset, software afterwards.
	always @(posedge clk_i) begin
		if (rst_i)
			oscillator_trim_value_o <= factory_cal_i;
		else if (wb_wr && wb_adr_i == `CSSC_OFF_TRIM)
			oscillator_trim_value_o <= wb_dat_i[7:0];
	end

	// -----------------------------------------------------------
	// Start-up sequencer
	// -----------------------------------------------------------
	wire sleep_req = (ctrl[`CSSC_CTRL_CORE] == 1'b0);
	wire wake = wake_s2 | ctrl[`CSSC_CTRL_WAKE];

	always @(posedge clk_i) begin
		if (rst_i) begin
			state <= ST_TOUT;
			from_reset <= 1'b1;
			tout_cnt <= 14'd0;
			start_cnt <= 16'd0;
		end else begin
			case (state)
				ST_TOUT: begin
					if (tout_cnt >= tout_len(eff_src, eff_sut)) begin
						state <= ST_START;
						start_cnt <= 16'd0;
					end else if (wdt_tick)
						tout_cnt <= tout_cnt + 14'd1;
				end
				ST_START: begin
					if (start_cnt >= start_len(eff_src, eff_sut, from_reset))
						state <= ST_RUN;
					else if (eff_src >= `CSSC_SRC_XCVR_MIN ? xtal_tick : osc_tick)
						start_cnt <= start_cnt + 16'd1;
				end
				ST_RUN: begin
					if (sleep_req)
						state <= ST_SLEEP;
				end
				ST_SLEEP: begin
					if (wake) begin
						state <= ST_START;
						from_reset <= 1'b0;
						start_cnt <= 16'd0;
					end
				end
				default: state <= ST_TOUT;
			endcase
		end
	end

	// -----------------------------------------------------------
	// Clock distribution
	// -----------------------------------------------------------
	always @(posedge clk_i) begin
		if (rst_i) begin
			internal_reset_o <= 1'b1;
			core_clock_en_o <= 1'b0;
			program_memory_clock_en_o <= 1'b0;
			peripheral_clock_en_o <= 1'b0;
			converter_clock_en_o <= 1'b0;
			async_timer_clock_en_o <= 1'b0;
			xcvr_clock_en_o <= 1'b0;
			async_detect_en_o <= 1'b0;
			div8_o <= 1'b0;
		end else begin
			internal_reset_o <= (state == ST_TOUT) || (state == ST_START && from_reset);
			core_clock_en_o <= (state == ST_RUN) & ctrl[`CSSC_CTRL_CORE];
			program_memory_clock_en_o <= (state == ST_RUN) & ctrl[`CSSC_CTRL_CORE];
			peripheral_clock_en_o <= (state == ST_RUN) & ctrl[`CSSC_CTRL_PERIPH];
			converter_clock_en_o <= ctrl[`CSSC_CTRL_CONV] & ~internal_reset_o;
			async_timer_clock_en_o <= asy_tick & ctrl[`CSSC_CTRL_ASY];
			xcvr_clock_en_o <= xtal_tick;
			async_detect_en_o <= ~peripheral_clock_en_o;
			div8_o <= ~div8;
		end
	end

endmodule

// ---- bench/cssc_clock_startup_asserts.sv ----
// Concurrent checks on the ports of the clock start-up block.
`timescale 1ns/1ps
module cssc_chk (
	// Clock, reset and bus
	input wire clk_i,
	input wire rst_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_ack_o,
	input wire [31:0] wb_dat_o,
	// Sequencing outputs
	input wire internal_reset_o,
	input wire core_clock_en_o,
	input wire program_memory_clock_en_o,
	input wire peripheral_clock_en_o,
	input wire async_detect_en_o,
	input wire div8_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_ans;
		wb_ack_o ##1 !wb_ack_o;
	endsequence
	a_ack_timing: assert property (s_req |=> s_ans) else $error("bus answer timing wrong");
	a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
	a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data outside ack");
	a_reset_hold: assert property ($fell(internal_reset_o) |-> $past(!rst_i, 1) && $past(!rst_i, 8))
		else $error("internal reset released too early");
	a_core_frozen: assert property (core_clock_en_o |-> !internal_reset_o) else $error("core runs in reset");
	a_flash_core: assert property (program_memory_clock_en_o == core_clock_en_o) else $error("flash gate");
	a_async_detect: assert property ($fell(peripheral_clock_en_o) |=> async_detect_en_o)
		else $error("async detect off");
	a_fuse_held: assert property ($past(!rst_i) && $past(!rst_i, 2) |-> $stable(div8_o))
		else $error("fuse changed");
endmodule
bind cssc_clock_startup cssc_chk i_cssc_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_dat_o,
	.internal_reset_o, .core_clock_en_o, .program_memory_clock_en_o, .peripheral_clock_en_o,
	.async_detect_en_o, .div8_o);

// ---- bench/tb.sv ----
// Self-checking bench for the clock start-up block.
`timescale 1ns/1ps
`include "cssc_defs.vh"
module tb;
	// ---------------------------------------------------------------
	// Stimulus and observed signals
	// ---------------------------------------------------------------
	reg clk_i = 1'b0;
	reg rst_i = 1'b1;
	reg [3:0] src = 4'h2;
	reg [1:0] startup_time_fuses = 2'h0;
	reg dv8 = 1'b0;
	reg cyc = 1'b0;
	reg stb = 1'b0;
	reg we = 1'b0;
	reg [7:0] adr = 8'h0;
	reg [31:0] dat = 32'h0;
	reg [31:0] q;
	reg [1:0] div = 2'h0;
	integer mismatches = 0;
	integer comparisons = 0;
	integer oe = 0;
	integer n;
	integer xc = 0;
	integer ac = 0;
	integer xn;
	integer an;
	wire xcv, asy;
	integer k;
	wire [31:0] dat_o;
	wire ack, irst, core, pmem, per, conv, adet, dv8o;
	wire [7:0] trim;
	wire osc = div[1];
	always #4 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		div <= div + 2'h1;
		if (div == 2'h1) oe <= oe + 1;
		xc <= xc + xcv;
		ac <= ac + asy;
	end
	cssc_clock_startup i_cssc_clock_startup (.clk_i(clk_i), .rst_i(rst_i), .clock_source_select_fuses_i(src),
		.startup_time_fuses_i(startup_time_fuses), .divide_by_eight_fuse_i(dv8), .factory_cal_i(8'h5a), .wdt_osc_i(osc),
		.sel_osc_i(osc), .xtal16_osc_i(osc), .async_osc_i(osc), .async_wake_i(1'b0), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(dat_o),
		.wb_ack_o(ack), .internal_reset_o(irst), .core_clock_en_o(core), .program_memory_clock_en_o(pmem),
		.peripheral_clock_en_o(per), .converter_clock_en_o(conv), .async_timer_clock_en_o(asy),
		.xcvr_clock_en_o(xcv), .async_detect_en_o(adet), .oscillator_trim_value_o(trim), .div8_o(dv8o));
	// ---------------------------------------------------------------
	// Tasks
	// ---------------------------------------------------------------
	task check(input [31:0] seen, input [31:0] exp);
		begin
			comparisons = comparisons + 1;
			if (seen !== exp) begin
				mismatches = mismatches + 1;
				$display("ERROR %0t seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task stop_test;
		begin
			if (mismatches == 0 && comparisons > 0)
				$display("TEST PASSED");
			else
				$display("TEST FAILED");
			$finish;
		end
	endtask
	task wb(input [7:0] a, input w, input [31:0] d);
		begin
			@(posedge clk_i);
			cyc <= 1'b1;
			stb <= 1'b1;
			we <= w;
			adr <= a;
			dat <= d;
			@(posedge clk_i);
			for (k = 0; k < 20 && ack !== 1'b1; k = k + 1)
				@(posedge clk_i);
			check({31'h0, ack}, 32'h1);
			q = dat_o;
			cyc <= 1'b0;
			stb <= 1'b0;
			repeat (3) @(posedge clk_i);
		end
	endtask
	task boot(input [3:0] s, input [1:0] t, input integer exp);
		begin
			src <= s;
			startup_time_fuses <= t;
			rst_i <= 1'b1;
			repeat (12) @(posedge clk_i);
			rst_i <= 1'b0;
			n = oe;
			for (k = 0; k < 40000 && irst !== 1'b0; k = k + 1)
				@(posedge clk_i);
			check(32'(oe - n >= exp && oe - n <= exp + 3), 32'h1);
		end
	endtask
	// ---------------------------------------------------------------
	// Test sequence
	// ---------------------------------------------------------------
	initial begin
		@(posedge clk_i);
		boot(4'h2, 2'h0, 14);
		boot(4'h2, 2'h1, 526);
		boot(4'h3, 2'h1, 526);
		dv8 <= 1'b1;
		boot(4'h0, 2'h0, 14);
		check(32'(dv8o), 32'h0);
		dv8 <= 1'b0;
		boot(4'h4, 2'h0, 14);
		boot(4'h2, 2'h2, 8206);
		check(32'(dv8o), 32'h1);
		wb(`CSSC_OFF_FUSE, 1'b0, 32'h0);
		check(q, 32'h22);
		wb(`CSSC_OFF_STATUS, 1'b0, 32'h0);
		check(q, 32'h14);
		wb(`CSSC_OFF_TRIM, 1'b0, 32'h0);
		check(q, 32'h5a);
		wb(`CSSC_OFF_TRIM, 1'b1, 32'h33);
		check(32'(trim), 32'h33);
		wb(8'h10, 1'b1, 32'hff);
		wb(8'h10, 1'b0, 32'h0);
		check(q, 32'h0);
		src <= 4'h0;
		wb(`CSSC_OFF_FUSE, 1'b0, 32'h0);
		check(q, 32'h22);
		wb(`CSSC_OFF_CTRL, 1'b0, 32'h0);
		check(q, 32'h0f);
		xn = xc;
		an = ac;
		repeat (40) @(posedge clk_i);
		check(32'(xc - xn >= 9 && xc - xn <= 11), 32'h1);
		check(32'(ac - an >= 9 && ac - an <= 11), 32'h1);
		wb(`CSSC_OFF_CTRL, 1'b1, 32'h0b);
		check({per, adet, core, conv}, 32'ha);
		wb(`CSSC_OFF_CTRL, 1'b1, 32'h0e);
		check({core, pmem, conv}, 32'h1);
		check({per, adet}, 32'h1);
		wb(`CSSC_OFF_CTRL, 1'b1, 32'h1b);
		n = oe;
		for (k = 0; k < 200 && core !== 1'b1; k = k + 1)
			@(posedge clk_i);
		check(32'(oe - n <= 9 && irst === 1'b0), 32'h1);
		wb(`CSSC_OFF_STATUS, 1'b0, 32'h0);
		check(q, 32'h04);
		stop_test;
	end
	initial begin
		#600000;
		mismatches = mismatches + 1;
		stop_test;
	end
endmodule
